// >>> mc_query_defs.sv
// Purpose: shared constants for the machine-check query unit, and its error log memory
// Assumes: one clock, synchronous log writes, registered read port
// Notes:   the package comes first so that the query unit, caller and bench can import it
package mc_query_pkg;
    localparam int DATA_W = 64;
    localparam int RAM_AW = 10;
    // apb register byte offsets
    localparam logic [7:0] OFS_INFO      = 8'h00;
    localparam logic [7:0] OFS_LEVEL_LO  = 8'h04;
    localparam logic [7:0] OFS_LEVEL_HI  = 8'h08;
    localparam logic [7:0] OFS_TYPE      = 8'h0C;
    localparam logic [7:0] OFS_CMD       = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_RESULT_LO = 8'h18;
    localparam logic [7:0] OFS_RESULT_HI = 8'h1C;
    localparam int CMD_GO_BIT    = 0;
    localparam int CMD_CLEAR_BIT = 1;
    localparam int STAT_INC_BIT  = 8;
    localparam int STAT_BUSY_BIT = 9;
    localparam int STAT_DONE_BIT = 10;
    // selector layout
    localparam int CID_LSB    = 0;
    localparam int TID_LSB    = 4;
    localparam int STRUCT_LSB = 8;
    localparam int NSTRUCT    = 40;
    localparam int RSVD_LSB   = 48;
    localparam logic [5:0] NSTRUCT_CODE = 6'h28;
    // info selector and type residues
    localparam logic [31:0] INFO_MAP    = 32'h0000_0000;
    localparam logic [31:0] INFO_STATE  = 32'h0000_0001;
    localparam logic [31:0] INFO_STRUCT = 32'h0000_0002;
    localparam int TYPE_MOD_W = 3;
    localparam logic [2:0] TYPE_WORD   = 3'h0;
    localparam logic [2:0] TYPE_TARGET = 3'h1;
    localparam logic [2:0] TYPE_REQ    = 3'h2;
    localparam logic [2:0] TYPE_RESP   = 3'h3;
    localparam logic [2:0] TYPE_IP     = 3'h4;
    // errors kept per structure, the bit of the type selector that counts them, and the first validity bit of the word
    localparam int MAX_ERR = 2;
    localparam int ERR_W   = 1;
    localparam int VLD_LSB = 60;
    // status codes, two's complement
    localparam logic [7:0] ST_OK      = 8'h00;
    localparam logic [7:0] ST_INVALID = 8'hFE;
    localparam logic [7:0] ST_ERROR   = 8'hFD;
    localparam logic [7:0] ST_NO_INFO = 8'hFA;
    typedef enum {Q_IDLE, Q_WAIT} qstate_t;
endpackage

`timescale 1ns/100ps
module mc_log_ram #(
    parameter int AW = 10,
    parameter int DW = 64
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read before write on a shared address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// >>> mc_query_unit.sv
// Purpose: machine-check error query unit behind an apb slave
// Assumes: log writes and ids synchronous to pclk; one query at a time
// Notes:   answers in one or two cycles after the go write
`timescale 1ns/100ps
module mc_query_unit (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [3:0]                  core_id,
    input  wire logic [3:0]                  thread_id,
    input  wire logic [mc_query_pkg::DATA_W-1:0] state_param,
    input  wire logic                        log_valid,
    input  wire logic [5:0]                  log_struct,
    input  wire logic                        log_err,
    input  wire logic [2:0]                  log_type,
    input  wire logic [mc_query_pkg::DATA_W-1:0] log_data
);
    import mc_query_pkg::*;

    logic [31:0]       info_sel;
    logic [31:0]       level_lo;
    logic [31:0]       level_hi;
    logic [31:0]       type_sel;
    logic [63:0]       sel;
    logic [3:0]        core_q;
    logic [3:0]        thread_q;
    logic [63:0]       state_q;
    logic [NSTRUCT-1:0] flags;
    logic [1:0]        cnt [NSTRUCT];
    logic [3:0]        vld [NSTRUCT][MAX_ERR];
    logic [63:0]       error_map;
    logic              go;
    logic              clear_log;
    logic              busy;
    logic              setup;
    logic              access;
    logic              wr_ok;
    logic              log_ok;
    logic [31:0]       rd_mux;
    logic              mapped;
    logic [5:0]        idx;
    logic [5:0]        nset;
    logic              e;
    logic [2:0]        tres;
    logic [1:0]        tix;
    logic              sel_bad;
    logic              err_ok;
    logic [7:0]        next_status;
    logic [63:0]       next_result;
    logic              need_mem;
    logic              next_inc;
    qstate_t           qstate;
    logic [5:0]        q_idx;
    logic              q_e;
    logic [2:0]        q_type;
    logic              q_inc;
    logic              collide;
    logic [7:0]        status_q;
    logic [63:0]       result_q;
    logic              inc_q;
    logic              done_q;
    logic [63:0]       mem_rdata;

    assign sel       = {level_hi, level_lo};
    assign error_map = {16'h0000, flags, thread_q, core_q};
    assign setup     = psel & ~penable;
    assign access    = psel & penable & pready;
    assign wr_ok     = access & pwrite & ~pslverr;
    assign busy      = go | (qstate == Q_WAIT);
    assign log_ok    = log_valid && (log_struct < NSTRUCT_CODE) && (log_type <= TYPE_IP);
    assign e         = type_sel[TYPE_MOD_W];
    assign tres      = type_sel[TYPE_MOD_W-1:0];
    assign tix       = 2'(tres - 3'h1);
    assign err_ok    = (type_sel[31:TYPE_MOD_W+ERR_W] == '0);

    // apb slave: zero wait, data and error registered at the setup edge
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_INFO:      rd_mux = info_sel;
            OFS_LEVEL_LO:  rd_mux = level_lo;
            OFS_LEVEL_HI:  rd_mux = level_hi;
            OFS_TYPE:      rd_mux = type_sel;
            OFS_CMD:       rd_mux = 32'h0000_0000;
            OFS_STATUS:    rd_mux = {21'h0, done_q, busy, inc_q, status_q};
            OFS_RESULT_LO: rd_mux = result_q[31:0];
            OFS_RESULT_HI: rd_mux = result_q[63:32];
            default:       mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup & ~pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // argument registers hold while a query runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            info_sel <= 32'h0000_0000;
            level_lo <= 32'h0000_0000;
            level_hi <= 32'h0000_0000;
            type_sel <= 32'h0000_0000;
        end else if (wr_ok && !busy) begin
            unique case (paddr)
                OFS_INFO:     info_sel <= pwdata;
                OFS_LEVEL_LO: level_lo <= pwdata;
                OFS_LEVEL_HI: level_hi <= pwdata;
                OFS_TYPE:     type_sel <= pwdata;
                default:      ;
            endcase
        end
    end

    // command pulses; a go during a running query is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go        <= 1'b0;
            clear_log <= 1'b0;
        end else begin
            go        <= wr_ok && (paddr == OFS_CMD) && pwdata[CMD_GO_BIT] && !busy;
            clear_log <= wr_ok && (paddr == OFS_CMD) && pwdata[CMD_CLEAR_BIT];
        end
    end

    // identity and state parameter captured every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_q   <= 4'h0;
            thread_q <= 4'h0;
            state_q  <= 64'h0;
        end else begin
            core_q   <= core_id;
            thread_q <= thread_id;
            state_q  <= state_param;
        end
    end

    // structure flags, error counts and validity; a new log beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
            for (int s = 0; s < NSTRUCT; s++) begin
                cnt[s] <= 2'h0;
                for (int k = 0; k < MAX_ERR; k++) begin
                    vld[s][k] <= 4'h0;
                end
            end
        end else begin
            if (clear_log) begin
                flags <= '0;
                for (int s = 0; s < NSTRUCT; s++) begin
                    cnt[s] <= 2'h0;
                    for (int k = 0; k < MAX_ERR; k++) begin
                        vld[s][k] <= 4'h0;
                    end
                end
            end
            if (log_ok) begin
                if (log_type == TYPE_WORD) begin
                    // one flag per level, set for either concurrent error slot
                    flags[log_struct] <= 1'b1;
                    if (cnt[log_struct] <= {1'b0, log_err} || clear_log) begin
                        cnt[log_struct] <= {1'b0, log_err} + 2'h1;
                    end
                end else begin
                    // snoop sources may hand in the incoming address as target
                    vld[log_struct][log_err][2'(log_type - 3'h1)] <= 1'b1;
                end
            end
        end
    end

    mc_log_ram #(
        .AW(RAM_AW),
        .DW(DATA_W)
    ) u_log (
        .clk   (pclk),
        .rst_n (presetn),
        .we    (log_ok),
        .waddr ({log_struct, log_err, log_type}),
        .wdata (log_data),
        .re    (go && need_mem),
        .raddr ({idx, e, tres}),
        .rdata (mem_rdata)
    );

    // one-hot search over bits 47:8, bit 8 is first level
    always_comb begin
        idx  = 6'h00;
        nset = 6'h00;
        for (int i = 0; i < NSTRUCT; i++) begin
            if (sel[STRUCT_LSB+i]) begin
                idx  = 6'(i);
                nset = nset + 6'h01;
            end
        end
    end

    assign sel_bad = (nset != 6'h01)
                  || (|sel[63:RSVD_LSB])
                  || (sel[TID_LSB-1:CID_LSB] != core_q)
                  || (sel[STRUCT_LSB-1:TID_LSB] != thread_q);

    always_comb begin
        next_status = ST_OK;
        next_result = 64'h0;
        need_mem    = 1'b0;
        next_inc    = 1'b0;
        if (info_sel == INFO_MAP) begin
            next_result = error_map;
        end else if (info_sel == INFO_STATE) begin
            next_result = state_q;
        end else if (info_sel != INFO_STRUCT) begin
            next_status = ST_INVALID;
        end else if (sel_bad || tres > TYPE_IP) begin
            next_status = ST_INVALID;
        end else if (!err_ok || cnt[idx] <= {1'b0, e}) begin
            next_status = ST_NO_INFO;
        end else if (tres != TYPE_WORD && !vld[idx][e][tix]) begin
            next_status = ST_NO_INFO;
        end else begin
            need_mem = 1'b1;
            next_inc = (cnt[idx] > ({1'b0, e} + 2'h1));
        end
    end

    // query engine; a log write to the same structure during a log memory read answers ST_ERROR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qstate   <= Q_IDLE;
            q_idx    <= 6'h00;
            q_e      <= 1'b0;
            q_type   <= 3'h0;
            q_inc    <= 1'b0;
            collide  <= 1'b0;
            status_q <= ST_OK;
            result_q <= 64'h0;
            inc_q    <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            unique case (qstate)
                Q_IDLE: begin
                    if (go) begin
                        done_q <= 1'b0;
                        if (need_mem) begin
                            qstate  <= Q_WAIT;
                            q_idx   <= idx;
                            q_e     <= e;
                            q_type  <= tres;
                            q_inc   <= next_inc;
                            collide <= log_ok && (log_struct == idx);
                        end else begin
                            status_q <= next_status;
                            result_q <= next_result;
                            inc_q    <= 1'b0;
                            done_q   <= 1'b1;
                        end
                    end
                end
                Q_WAIT: begin
                    qstate <= Q_IDLE;
                    done_q <= 1'b1;
                    inc_q  <= q_inc;
                    if (collide || (log_ok && log_struct == q_idx)) begin
                        status_q <= ST_ERROR;
                    end else begin
                        status_q <= ST_OK;
                    end
                    if (q_type == TYPE_WORD) begin
                        // validity flags overlay the top nibble of the word
                        result_q <= {mem_rdata[63:VLD_LSB] | vld[q_idx][q_e],
                                     mem_rdata[VLD_LSB-1:0]};
                    end else begin
                        // target, requester, responder or bundle address
                        result_q <= mem_rdata;
                    end
                end
            endcase
        end
    end

    // checks
    AST_MAP_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        go && info_sel == INFO_MAP |=> result_q == $past(error_map) && status_q == ST_OK)
        else $error("error map query returned wrong word");

    AST_STATE_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        go && info_sel == INFO_STATE |=> result_q == $past(state_q) && done_q)
        else $error("state parameter query returned wrong word");

    AST_MULTI_BIT: assert property (@(posedge pclk) disable iff (!presetn)
        go && info_sel == INFO_STRUCT && nset != 6'h01 |=> status_q == ST_INVALID)
        else $error("several structure bits not refused");

    AST_BAD_INFO: assert property (@(posedge pclk) disable iff (!presetn)
        go && info_sel > INFO_STRUCT |=> status_q == ST_INVALID && result_q == 64'h0)
        else $error("reserved info selector not refused");

    AST_BAD_TYPE: assert property (@(posedge pclk) disable iff (!presetn)
        go && info_sel == INFO_STRUCT && tres > TYPE_IP |=> status_q == ST_INVALID)
        else $error("reserved type residue not refused");

    AST_MAP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        log_ok && log_type == TYPE_WORD |=> error_map[STRUCT_LSB + $past(log_struct)])
        else $error("logged structure missing from error map");

    AST_ANSWER_TIME: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> ##[0:1] done_q)
        else $error("query not answered within two cycles");

    AST_INC_OK: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(inc_q) |-> status_q != ST_INVALID && status_q != ST_NO_INFO)
        else $error("more-errors flag on a failed query");

    AST_ID_FIELDS: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> error_map[7:0] == {$past(thread_id), $past(core_id)})
        else $error("core or thread id missing from error map");

    COV_MAP_QUERY: cover property (@(posedge pclk) disable iff (!presetn)
        go && info_sel == INFO_MAP);
    COV_DETAIL_OK: cover property (@(posedge pclk) disable iff (!presetn)
        qstate == Q_WAIT ##1 status_q == ST_OK);
    COV_MORE_ERRORS: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(inc_q));
    COV_REFUSED: cover property (@(posedge pclk) disable iff (!presetn)
        go ##1 status_q == ST_INVALID);
endmodule

// >>> mc_caller.sv
// Purpose: apb caller model that issues machine-check queries
// Assumes: slave may insert wait states; pready sampled at the rising edge
// Notes:   request held until pready is seen high, then released
`timescale 1ns/100ps
module mc_caller (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    import mc_query_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hA5A5_A5A5;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus shows junk, not the old request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // one selector bit per detail query unless a refusal is wanted
    task automatic query(input logic [31:0] info, input logic [63:0] lvl,
                         input logic [31:0] typ, output logic [63:0] res,
                         output logic [31:0] st);
        logic [31:0] r;
        logic        e;
        apb(1'b1, OFS_INFO, info, r, e);
        apb(1'b1, OFS_LEVEL_LO, lvl[31:0], r, e);
        apb(1'b1, OFS_LEVEL_HI, lvl[63:32], r, e);
        apb(1'b1, OFS_TYPE, typ, r, e);
        apb(1'b1, OFS_CMD, 32'h0000_0001, r, e);
        // poll until done; only the bench timeout ends a hang
        do apb(1'b0, OFS_STATUS, 32'h0000_0000, st, e);
        while (st[STAT_DONE_BIT] !== 1'b1);
        apb(1'b0, OFS_RESULT_LO, 32'h0000_0000, res[31:0], e);
        apb(1'b0, OFS_RESULT_HI, 32'h0000_0000, res[63:32], e);
    endtask
endmodule

// >>> machine_check_error_query_test.sv
// Purpose: self-checking bench for the machine-check query unit
// Assumes: log port written by the bench, queries issued by the caller model
// Notes:   error-status cases do not judge the more-errors flag
`timescale 1ns/100ps
module machine_check_error_query_test;
    import mc_query_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  core_id = 4'h3;
    logic [3:0]  thread_id = 4'h5;
    logic [63:0] state_param = 64'hFEDC_BA98_7654_3210;
    logic        log_valid = 1'b0;
    logic [5:0]  log_struct = 6'h00;
    logic        log_err = 1'b0;
    logic [2:0]  log_type = 3'h0;
    logic [63:0] log_data = 64'h0;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    localparam logic [63:0] LV = 64'h0000_0000_0000_0153;
    localparam logic [63:0] W0 = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] W1 = 64'h0000_0000_0000_00AA;
    localparam logic [63:0] W2 = 64'h0A0A_0000_5555_0000;
    localparam logic [63:0] TGT = 64'h0000_0000_8000_1000;
    always #20 pclk = ~pclk;
    mc_query_unit u_mc_query_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_id(core_id),
        .thread_id(thread_id), .state_param(state_param), .log_valid(log_valid),
        .log_struct(log_struct), .log_err(log_err), .log_type(log_type),
        .log_data(log_data));
    mc_caller u_mc_caller (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic q(input logic [31:0] info, input logic [63:0] lvl, input logic [31:0] typ,
                     input logic [63:0] er, input logic inc, input logic [7:0] code);
        logic [63:0] res;
        logic [31:0] st;
        u_mc_caller.query(info, lvl, typ, res, st);
        chk(res, er);
        chk({54'h0, st[10:9], st[7:0]}, {54'h0, 2'b10, code});
        if (code == ST_OK) chk({63'h0, st[STAT_INC_BIT]}, {63'h0, inc});
    endtask
    task automatic logw(input logic [5:0] s, input logic e, input logic [2:0] t,
                        input logic [63:0] d);
        @(posedge pclk);
        log_valid <= 1'b1;
        log_struct <= s;
        log_err <= e;
        log_type <= t;
        log_data <= d;
        @(posedge pclk);
        log_valid <= 1'b0;
        log_data <= ~d;
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        u_mc_caller.apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk({32'h0, r}, 64'h0);
        u_mc_caller.apb(1'b1, 8'h40, 32'h0000_0001, r, e);
        chk({63'h0, e}, 64'h1);
        $display("test regs done");
    endtask
    task automatic t_map();
        logw(6'h00, 1'b0, 3'h0, W0);
        logw(6'h00, 1'b0, 3'h1, TGT);
        logw(6'h00, 1'b1, 3'h0, W1);
        logw(6'h27, 1'b0, 3'h0, W2);
        // selector junk must be ignored here
        q(INFO_MAP, 64'hFFFF_0000_0000_3300, 32'h5, 64'h0000_8000_0000_0153, 1'b0, ST_OK);
        q(INFO_STATE, 64'h0, 32'h7, 64'hFEDC_BA98_7654_3210, 1'b0, ST_OK);
        $display("test map done");
    endtask
    task automatic t_detail();
        q(INFO_STRUCT, LV, 32'h0, W0 | 64'h1000_0000_0000_0000, 1'b1, ST_OK);
        q(INFO_STRUCT, LV, 32'h1, TGT, 1'b1, ST_OK);
        for (int t = 2; t < 5; t++) q(INFO_STRUCT, LV, t, 64'h0, 1'b0, ST_NO_INFO);
        q(INFO_STRUCT, LV, 32'h8, W1, 1'b0, ST_OK);
        q(INFO_STRUCT, LV, 32'h10, 64'h0, 1'b0, ST_NO_INFO);
        q(INFO_STRUCT, 64'h0000_8000_0000_0053, 32'h0, W2, 1'b0, ST_OK);
        // log write to the queried structure while the word is being read
        fork
            q(INFO_STRUCT, LV, 32'h0, W0 | 64'h1000_0000_0000_0000, 1'b1, ST_ERROR);
            begin
                @(posedge pclk iff (psel && penable && paddr == OFS_CMD));
                logw(6'h00, 1'b0, 3'h1, TGT);
            end
        join
        $display("test detail done");
    endtask
    task automatic t_refuse();
        logic [31:0] r;
        logic        e;
        for (int t = 5; t < 8; t++) q(INFO_STRUCT, LV, t, 64'h0, 1'b0, ST_INVALID);
        q(INFO_STRUCT, LV | 64'h1000, 32'h0, 64'h0, 1'b0, ST_INVALID);
        q(INFO_STRUCT, LV | 64'h0001_0000_0000_0000, 32'h0, 64'h0, 1'b0, ST_INVALID);
        q(INFO_STRUCT, LV ^ 64'h1, 32'h0, 64'h0, 1'b0, ST_INVALID);
        q(32'h3, LV, 32'h0, 64'h0, 1'b0, ST_INVALID);
        // clear drops every logged flag
        u_mc_caller.apb(1'b1, OFS_CMD, 32'h0000_0002, r, e);
        q(INFO_MAP, 64'h0, 32'h0, 64'h53, 1'b0, ST_OK);
        $display("test refuse done");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_map();
        t_detail();
        t_refuse();
        print_verdict();
    end
endmodule
